//--- sbsp_pkg.sv
package sbsp_pkg;
    // Burst counter geometry
    localparam int         BURST_W     = 2;
    localparam logic [1:0] CNT_ZERO    = 2'h0;
    localparam logic [1:0] CNT_ONE     = 2'h1;
    // Data geometry defaults (four bytes of nine bits)
    localparam int         BYTE_W      = 9;
    localparam int         NUM_BYTES   = 4;
    localparam int         ADDR_W      = 18;
    // Buffer geometry
    localparam int         BUF_DEPTH   = 2;
    // Strap levels: low picks linear order
    localparam logic       MODE_LINEAR = 1'h0;

    // Port state, one-hot
    typedef enum logic [2:0] {
        ST_DESEL  = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_SLEEP  = 3'h4
    } sbsp_state_t;
endpackage

//--- sbsp_buf2.sv
// Two-entry buffer; outputs come straight from the entry flops
module sbsp_buf2 #(
    parameter int W = 36
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] ent_ff [2];   // Entry storage
    logic         wr_ptr_ff;    // Next entry to fill
    logic         rd_ptr_ff;    // Head entry
    logic [1:0]   cnt_ff;       // Occupancy, 0..2
    logic         push;
    logic         pop;

    // Refuse a zero-width entry
    if (W < 1) begin : g_chk_w
        $error("sbsp_buf2: W too small");
    end

    // Honest full and empty from the occupancy count
    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = ent_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Entry writes; no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (push) begin
            ent_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff <= 1'h0;
            rd_ptr_ff <= 1'h0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            // Simultaneous push and pop keep the count
            cnt_ff <= 2'(cnt_ff + {1'h0, push} - {1'h0, pop});
        end
    end
endmodule // sbsp_buf2

//--- sbsp_port.sv
// Notes on behaviour
// - Capture address only with strobe and selection
// - Two low address bits feed burst counter
// - Byte select writes only with byte enable
// - Byte write needs byte enable low
// - Global write writes every byte
// - Advance low steps counter, else hold
// - Processor strobe loads address and counter
// - Controller strobe loads address and counter
// - Both strobes low: processor strobe wins
// - Processor strobe ignored while first select high
// - Selects sampled only on address loads
// - Selected: first, third low; second high
// - Missing third select counts as asserted
// - Output enable low drives data pins
// - First read after deselect keeps outputs off
// - Sleep high idles, data kept
// - Unconnected sleep reads as low
// - Strap low linear, high interleaved order
// - Read data follows previous edge address
// - Counter wraps after four addresses
module sbsp_port #(
    parameter int ADDR_W    = sbsp_pkg::ADDR_W,
    parameter int BYTE_W    = sbsp_pkg::BYTE_W,
    parameter int NUM_BYTES = sbsp_pkg::NUM_BYTES,
    parameter bit HAS_CE3   = 1'b1
) (
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic [ADDR_W-1:0]           addr,
    input  wire logic                        processor_addr_strobe_n,
    input  wire logic                        controller_addr_strobe_n,
    input  wire logic                        burst_advance_n,
    input  wire logic                        global_write_n,
    input  wire logic                        byte_write_enable_n,
    input  wire logic [NUM_BYTES-1:0]        byte_write_select_n,
    input  wire logic                        chip_select_first_n,
    input  wire logic                        chip_select_second,
    input  wire logic                        chip_select_third_n,
    input  wire logic                        output_enable_n,
    input  wire logic                        sleep_request,
    input  wire logic                        burst_mode,
    input  wire logic [NUM_BYTES*BYTE_W-1:0] dq_in,
    output logic      [NUM_BYTES*BYTE_W-1:0] dq_out,
    output logic                             dq_oe,
    output logic                             rd_data_valid,
    input  wire logic                        rd_data_ready,
    output logic                             sleeping
);
    localparam int DW = NUM_BYTES * BYTE_W;

    // Refuse shapes the burst logic cannot serve
    if (ADDR_W < sbsp_pkg::BURST_W + 1) begin : g_chk_addr
        $error("sbsp_port: ADDR_W too small");
    end
    if (NUM_BYTES < 1 || BYTE_W < 1) begin : g_chk_data
        $error("sbsp_port: bad data shape");
    end

    // Next low address bits from start and count
    function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt, input logic lin);
        if (lin == 1'b1) begin
            burst_low = 2'(start + cnt);
        end else begin
            burst_low = start ^ cnt;
        end
    endfunction

    logic [DW-1:0]          mem [2**ADDR_W];   // Storage array, kept through sleep
    sbsp_pkg::sbsp_state_t  state_ff;          // Port state
    sbsp_pkg::sbsp_state_t  nxt_state;
    logic [ADDR_W-1:0]      base_ff;           // Captured address
    logic [1:0]             cnt_ff;            // Burst step count
    logic [1:0]             nxt_cnt;
    logic [2:0]             slp_sync_ff;       // Sleep synchroniser chain
    logic                   sleep_ff;          // Filtered sleep level
    logic                   linear_ff;         // Burst order strap
    logic                   strap_done_ff;     // Strap caught once
    logic                   rd_req_ff;         // Read issued last edge
    logic [ADDR_W-1:0]      rd_addr_ff;        // Address of that read
    logic                   mask_ff;           // Output mask after deselect
    logic                   buf_ready;         // Room in the read buffer
    logic                   buf_in_ready;      // Buffer has a free entry now
    logic                   ce_ok;
    logic                   load_p;
    logic                   load_c;
    logic                   load;
    logic                   cont;
    logic                   access;
    logic [ADDR_W-1:0]      acc_addr;
    logic [NUM_BYTES-1:0]   wr_mask;
    logic                   is_write;
    logic                   rd_access;

    // Selection decode; absent third select is tied active
    assign ce_ok = !chip_select_first_n && chip_select_second
                   && (!chip_select_third_n || !HAS_CE3);

    // Strobe decode; processor strobe needs first select low
    assign load_p = !processor_addr_strobe_n && !chip_select_first_n;
    assign load_c = !controller_addr_strobe_n && !load_p;
    assign load   = (load_p || load_c) && !sleep_ff;

    // Burst continuation holds while buffer is full
    assign cont   = (state_ff == sbsp_pkg::ST_ACTIVE) && !load && !sleep_ff;
    assign access = ((load && ce_ok) || cont) && buf_ready;

    // Address of this edge's access
    always_comb begin
        if (load) begin
            acc_addr = addr;
        end else begin
            acc_addr = {base_ff[ADDR_W-1:2], burst_low(base_ff[1:0], nxt_cnt, linear_ff)};
        end
    end

    // Write qualification: global write overrides byte controls
    always_comb begin
        if (!global_write_n) begin
            wr_mask = '1;
        end else if (!byte_write_enable_n) begin
            wr_mask = ~byte_write_select_n;
        end else begin
            wr_mask = '0;
        end
    end
    assign is_write  = access && (wr_mask != '0);
    assign rd_access = access && (wr_mask == '0);

    // Port state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sbsp_pkg::ST_DESEL, sbsp_pkg::ST_ACTIVE: begin
                if (sleep_ff) begin
                    nxt_state = sbsp_pkg::ST_SLEEP;
                end else if (load && (buf_ready || !ce_ok)) begin
                    // A selected load waits for buffer room; a deselect never does
                    // Selects only matter on a load
                    nxt_state = ce_ok ? sbsp_pkg::ST_ACTIVE : sbsp_pkg::ST_DESEL;
                end
            end
            sbsp_pkg::ST_SLEEP: begin
                if (!sleep_ff) begin
                    nxt_state = sbsp_pkg::ST_DESEL;
                end
            end
            default: begin
                nxt_state = sbsp_pkg::ST_DESEL;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= sbsp_pkg::ST_DESEL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Counter step: selected load clears, advance steps, else hold
    always_comb begin
        nxt_cnt = cnt_ff;
        if (cont && !burst_advance_n && buf_ready) begin
            nxt_cnt = 2'(cnt_ff + sbsp_pkg::CNT_ONE);
        end
    end

    // Address and burst registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            base_ff <= '0;
            cnt_ff  <= sbsp_pkg::CNT_ZERO;
        end else if (load && ce_ok && buf_ready) begin
            base_ff <= addr;
            cnt_ff  <= sbsp_pkg::CNT_ZERO;
        end else begin
            cnt_ff  <= nxt_cnt;
        end
    end

    // Sleep synchroniser; reset value stands in for the pull-down
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slp_sync_ff <= 3'h0;
            sleep_ff    <= 1'h0;
        end else begin
            slp_sync_ff <= {slp_sync_ff[1:0], sleep_request};
            // Count a change only once stages two and three agree
            if (slp_sync_ff[1] == slp_sync_ff[2]) begin
                sleep_ff <= slp_sync_ff[2];
            end
        end
    end
    assign sleeping = (state_ff == sbsp_pkg::ST_SLEEP);

    // Strap caught at first edge after reset; later changes ignored
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_ff <= 1'h0;
            linear_ff     <= 1'h0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'h1;
            linear_ff     <= (burst_mode == sbsp_pkg::MODE_LINEAR);
        end
    end

    // Byte-wise writes into the array
    always_ff @(posedge clk_sys) begin
        if (is_write) begin
            for (int b = 0; b < NUM_BYTES; b++) begin
                if (wr_mask[b]) begin
                    mem[acc_addr][b*BYTE_W +: BYTE_W] <= dq_in[b*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    // Read pipeline stage and deselect mask
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_req_ff  <= 1'h0;
            rd_addr_ff <= '0;
            mask_ff    <= 1'h0;
        end else begin
            rd_req_ff  <= rd_access;
            if (rd_access) begin
                rd_addr_ff <= acc_addr;
            end
            // Read emerging from deselect keeps outputs off a clock
            mask_ff <= rd_access && (state_ff != sbsp_pkg::ST_ACTIVE);
        end
    end

    // Read buffer; a receiver stall backs up into the burst
    sbsp_buf2 #(
        .W (DW)
    ) u_buf (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (rd_req_ff),
        .in_ready  (buf_in_ready),
        .in_data   (mem[rd_addr_ff]),
        .out_valid (rd_data_valid),
        .out_ready (rd_data_ready),
        .out_data  (dq_out)
    );

    // Room for the word issued now: the one in flight must still fit
    // Pops are counted, so a receiver that keeps up sees no bubble
    assign buf_ready = buf_in_ready && !(rd_data_valid && rd_req_ff && !rd_data_ready);

    // Pin direction follows the asynchronous output enable
    assign dq_oe = !output_enable_n && !mask_ff && !sleep_ff;

    // Named steps of a read
    sequence s_rd_issue;
        rd_access;
    endsequence

    sequence s_rd_push;
        rd_req_ff && (rd_addr_ff == $past(acc_addr));
    endsequence

    property p_read_latency;
        @(posedge clk_sys) disable iff (sys_rst) s_rd_issue |=> s_rd_push;
    endproperty

    a_load_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (load && ce_ok && buf_ready) |=> (base_ff == $past(addr)) && (cnt_ff == sbsp_pkg::CNT_ZERO))
        else $error("address not captured on selected load");

    a_cs_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (load && buf_ready && !chip_select_first_n && chip_select_second && !chip_select_third_n)
        |=> (state_ff == sbsp_pkg::ST_ACTIVE || sleeping))
        else $error("select pattern did not select");

    a_psel_ignore: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!processor_addr_strobe_n && chip_select_first_n && controller_addr_strobe_n && !sleep_ff && !sleeping)
        |=> state_ff == $past(state_ff))
        else $error("processor strobe acted with first select high");

    a_both_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!processor_addr_strobe_n && !controller_addr_strobe_n && !chip_select_first_n) |-> !load_c)
        else $error("controller strobe not disregarded");

    a_burst_adv: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cont && buf_ready && !burst_advance_n) |=> cnt_ff == $past(cnt_ff) + 2'h1)
        else $error("burst counter did not advance");

    a_burst_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cont && burst_advance_n) |=> $stable(cnt_ff))
        else $error("burst counter moved without advance");

    a_global_wr: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && !global_write_n) |-> is_write && (&wr_mask) && !rd_access)
        else $error("global write did not cover all bytes");

    a_oe_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rd_access && state_ff == sbsp_pkg::ST_DESEL) |=> !dq_oe)
        else $error("outputs enabled on first read after deselect");

    a_read_lat: assert property (p_read_latency)
        else $error("read not pushed one clock after issue");

    a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep_ff |-> !dq_oe && !access && !is_write)
        else $error("activity during sleep");

    // Buffer room, burst geometry, write qualification, output enable and sleep entry
    a_buf_no_loss: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rd_req_ff |-> buf_in_ready)
        else $error("read word dropped at full buffer");

    a_burst_page: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && !load) |-> acc_addr[ADDR_W-1:2] == base_ff[ADDR_W-1:2])
        else $error("burst left its four-word group");

    a_lin_order: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && !load && linear_ff) |-> 2'(acc_addr[1:0] - base_ff[1:0]) == nxt_cnt)
        else $error("linear burst order broken");

    a_ilv_order: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && !load && !linear_ff) |-> (acc_addr[1:0] ^ base_ff[1:0]) == nxt_cnt)
        else $error("interleaved burst order broken");

    a_base_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cont |=> $stable(base_ff))
        else $error("address moved during internal burst");

    a_strap_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        strap_done_ff |=> $stable(linear_ff))
        else $error("burst order changed after capture");

    a_byte_qual: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && global_write_n && byte_write_enable_n) |-> !is_write)
        else $error("byte write without byte enable");

    a_read_dflt: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (access && global_write_n && (byte_write_enable_n || (&byte_write_select_n))) |-> rd_access)
        else $error("unqualified access not treated as read");

    a_oe_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
        output_enable_n |-> !dq_oe)
        else $error("data pins driven with output enable high");

    a_sleep_enter: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (sleep_ff && !sleeping) |=> sleeping)
        else $error("sleep state not entered");
endmodule // sbsp_port

//--- sbsp_ctl_model.sv
// Cache controller model driving the synchronous burst bus
module sbsp_ctl_model (
    input  wire logic   clk_sys,
    output logic [17:0] addr,
    output logic        processor_addr_strobe_n,
    output logic        controller_addr_strobe_n,
    output logic        burst_advance_n,
    output logic        global_write_n,
    output logic        byte_write_enable_n,
    output logic [3:0]  byte_write_select_n,
    output logic        chip_select_first_n,
    output logic        chip_select_second,
    output logic        chip_select_third_n,
    output logic        output_enable_n,
    output logic        sleep_request,
    output logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet bus at time zero, strobes parked high
    initial begin
        {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
        {burst_advance_n, global_write_n, byte_write_enable_n} = 3'h7;
        {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h4;
        byte_write_select_n = 4'hf;
        output_enable_n = 1'h0;
        sleep_request = 1'h0; // Normal operation keeps sleep low
        addr = 18'h0_0000;
        dq_in = 36'h0_0000_0000;
    end

    // One bus clock: change just after the edge, hold to the next edge
    // Control order: strobes, three selects, advance, global, byte enable
    task automatic cyc(input logic [7:0] c, input logic [3:0] bws, input logic [17:0] a, input logic [35:0] d);
        @(posedge clk_sys);
        #1;
        {processor_addr_strobe_n, controller_addr_strobe_n} <= c[7:6];
        {chip_select_first_n, chip_select_second, chip_select_third_n} <= c[5:3];
        {burst_advance_n, global_write_n, byte_write_enable_n} <= c[2:0];
        byte_write_select_n <= bws;
        addr <= a;
        // Idle data lines toggle so a stale word never looks right
        dq_in <= (!c[1] || !c[0]) ? d : ~dq_in;
    endtask
endmodule // sbsp_ctl_model

//--- tb_top.sv
// Self-checking bench for the burst port
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] DESEL = 8'hb7; // Controller strobe, first select off
    logic        clk_sys = 1'h0;
    logic        sys_rst = 1'h1;
    logic        burst_mode = 1'h0;
    logic        rd_data_ready = 1'h1;
    logic [17:0] addr;
    logic        processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
    logic        global_write_n, byte_write_enable_n, output_enable_n, sleep_request;
    logic [3:0]  byte_write_select_n;
    logic        chip_select_first_n, chip_select_second, chip_select_third_n;
    logic [35:0] dq_in, dq_out, stall_val;
    logic        dq_oe, rd_data_valid, sleeping, act, stall_mode = 1'h0;
    logic [17:0] base, wa [4];
    logic [1:0]  cnt;
    logic [35:0] mem [logic [17:0]]; // Reference storage
    logic [35:0] exp_q [$];          // Reads still owed by the port
    int          error_cnt = 0;
    int          checks = 0;
    int          seed = 3399;

    initial forever #2 clk_sys = ~clk_sys;
    sbsp_port dut_u (.*);
    sbsp_ctl_model ctl_u (.*);

    // Burst address from start bits and count
    function automatic logic [17:0] baddr(input logic [17:0] b, input logic [1:0] c);
        return {b[17:2], burst_mode ? b[1:0] ^ c : b[1:0] + c};
    endfunction

    function automatic logic [35:0] rnd();
        logic [63:0] v;
        v = {$random(seed), $random(seed)};
        return v[35:0];
    endfunction

    // Reference port: state, counter, storage and owed reads
    always @(posedge clk_sys) begin
        if (sys_rst || sleeping) begin
            act = 1'h0;
        end else begin
            if ((!processor_addr_strobe_n && !chip_select_first_n) || !controller_addr_strobe_n) begin
                act = !chip_select_first_n && chip_select_second && !chip_select_third_n;
                base = addr;
                cnt = 2'h0;
            end else if (!burst_advance_n) begin
                cnt = cnt + 2'h1;
            end
            if (act && !stall_mode) begin
                if (!global_write_n) begin
                    mem[baddr(base, cnt)] = dq_in;
                end else if (!byte_write_enable_n && byte_write_select_n != 4'hf) begin
                    for (int b = 0; b < 4; b++) begin
                        if (!byte_write_select_n[b]) mem[baddr(base, cnt)][9*b+:9] = dq_in[9*b+:9];
                    end
                end else begin
                    exp_q.push_back(mem[baddr(base, cnt)]);
                end
            end
        end
    end

    // Receiver side: every accepted word is compared
    always @(posedge clk_sys) begin
        if (!sys_rst && rd_data_valid === 1'h1 && rd_data_ready) begin
            if (stall_mode) chk_word(dq_out, stall_val);
            else if (exp_q.size() == 0) chk_bit(1'h0, 1'h1);
            else chk_word(dq_out, exp_q.pop_front());
        end
    end

    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Either strobe or both; never neither
    function automatic logic [1:0] strobes();
        logic [1:0] s;
        s = 2'($random(seed));
        return (s == 2'h3) ? 2'h2 : s;
    endfunction

    task automatic do_reset();
        @(posedge clk_sys);
        #1;
        sys_rst = 1'h1;
        repeat (8) @(posedge clk_sys);
        #1;
        sys_rst = 1'h0;
    endtask

    // Global write burst of four, last three with advance low
    task automatic wr_burst(input logic [17:0] a);
        ctl_u.cyc({strobes(), 3'h2, 3'h5}, 4'h0, a, rnd());
        repeat (3) ctl_u.cyc({2'h3, 3'(rnd()), 3'h1}, 4'h0, 18'(rnd()), rnd());
        ctl_u.cyc(DESEL, 4'hf, a, rnd());
    endtask

    // Read from deselect: masked clock, held address, wrap
    task automatic rd_burst(input logic [17:0] a);
        ctl_u.cyc({strobes(), 3'h2, 3'h7}, 4'hf, a, rnd());
        ctl_u.cyc({2'h3, 3'h2, 3'h3}, 4'hf, a, rnd());
        chk_bit(dq_oe, 1'h0);
        ctl_u.cyc({1'h0, 1'h1, 1'h1, 2'(rnd()), 3'h7}, 4'hf, ~a, rnd());
        chk_bit(dq_oe, 1'h1);
        repeat (4) ctl_u.cyc({2'h3, 3'(rnd()), 3'h3}, 4'hf, ~a, rnd());
        repeat (4) ctl_u.cyc(DESEL, 4'hf, a, rnd());
        chk_bit(exp_q.size() == 0, 1'h1);
    endtask

    initial begin
        do_reset();
        foreach (wa[i]) begin
            wa[i] = 18'(rnd());
            wr_burst(wa[i]);
            rd_burst(wa[i]);
        end
        $display("test linear bursts done");
        foreach (wa[i]) begin
            ctl_u.cyc({strobes(), 3'h2, 3'h6}, 4'(rnd()), wa[i], rnd());
            ctl_u.cyc({2'h3, 3'h2, 3'h3}, 4'h0, wa[i], rnd());
            ctl_u.cyc({2'h3, 3'h2, 3'h2}, 4'h0, wa[i], rnd());
            ctl_u.cyc(DESEL, 4'hf, wa[i], rnd());
            rd_burst(wa[i]);
        end
        ctl_u.output_enable_n = 1'h1;
        #1 chk_bit(dq_oe, 1'h0);
        ctl_u.output_enable_n = 1'h0;
        #1 chk_bit(dq_oe, 1'h1);
        $display("test byte writes done");
        for (int j = 0; j < 8; j++) begin
            ctl_u.cyc({2'h2, 3'(j), 3'h7}, 4'hf, wa[0], rnd());
            ctl_u.cyc(DESEL, 4'hf, wa[0], rnd());
        end
        repeat (3) ctl_u.cyc(DESEL, 4'hf, wa[0], rnd());
        chk_bit(exp_q.size() == 0, 1'h1);
        $display("test selects done");
        stall_val = mem[wa[1]];
        stall_mode = 1'h1;
        rd_data_ready = 1'h0;
        ctl_u.cyc({2'h2, 3'h2, 3'h7}, 4'hf, wa[1], rnd());
        repeat (5) ctl_u.cyc({2'h3, 3'h2, 3'h7}, 4'hf, wa[1], rnd());
        repeat (4) ctl_u.cyc(DESEL, 4'hf, wa[1], rnd());
        chk_bit(rd_data_valid, 1'h1);
        chk_word(dq_out, stall_val);
        rd_data_ready = 1'h1;
        repeat (5) ctl_u.cyc(DESEL, 4'hf, wa[1], rnd());
        chk_bit(rd_data_valid, 1'h0);
        stall_mode = 1'h0;
        $display("test stall done");
        ctl_u.sleep_request = 1'h1;
        for (int k = 0; k < 10 && sleeping !== 1'h1; k++) #4;
        chk_bit(sleeping, 1'h1);
        ctl_u.cyc({2'h0, 3'h2, 3'h7}, 4'hf, wa[2], rnd());
        repeat (4) ctl_u.cyc({2'h3, 3'h2, 3'h7}, 4'hf, wa[2], rnd());
        chk_bit(rd_data_valid, 1'h0);
        ctl_u.sleep_request = 1'h0;
        for (int k = 0; k < 10 && sleeping !== 1'h0; k++) #4;
        chk_bit(sleeping, 1'h0);
        rd_burst(wa[2]);
        $display("test sleep done");
        burst_mode = 1'h1;
        do_reset();
        wr_burst(wa[3]);
        rd_burst(wa[3]);
        $display("test interleaved done");
        conclude();
    end

    // Watchdog well beyond the expected run
    initial begin
        #100_000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        conclude();
    end
endmodule // tb_top
